/* File: hdl/cmx_clock_router.sv */
// Overview of operation
// - Path A divide code comes from image bits 99 to 96.
// - Path B divide code comes from image bits 103 to 100.
// - Path C uses bits 107-104 with select low, 115-112 with select high.
// - Path D uses bits 111-108 with select low, 119-116 with select high.
// - Codes 0 to 15 divide by 1,2,3,4,5,6,8,9,10,12,15,16,18,20,25,50.
// - A and B source selects: 00 reference, 01 pll A, 10 pll B, 11 pll C.
// - C and D sources: bits 71-70, 95-94 select low; 125-124, 127-126 high.
// - Loop filter bit zero gives short constant, one gives long constant.
// - Charge pump bit zero gives low current, one gives high current.
// - Pll C tuning uses first bit pair with select low, second pair high.
// - Selector or divider changes may glitch; pll bit changes slew smoothly.
// - Divider with sleep bit set stops while power-down pin high in run mode.
// - Whole configuration image is zero after reset.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`include "cmx_params.svh"

module cmx_clock_router #(
    parameter int PATHS = 4,
    parameter int CNT_W = 6
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire cmx_pkg::cmx_axi_req_t axi_req,
    output cmx_pkg::cmx_axi_rsp_t axi_rsp,
    input wire logic cd_config_select,
    input wire logic power_down_pin,
    input wire logic run_mode,
    input wire logic [3:0] src_tick,
    output logic [PATHS-1:0] out_tick,
    output logic [PATHS-1:0] out_clk,
    output cmx_pkg::cmx_pll_tune_t [2:0] pll_tune
);
    import cmx_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed
    {
        logic [3:0][31:0] image;
        logic aw_rdy;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_rdy;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        cmx_pll_tune_t [2:0] tune;
    } cmx_state_t;

    cmx_state_t state;
    cmx_state_t next_state;

    logic [127:0] image_flat;
    logic [PATHS-1:0][3:0] eff_code;
    logic [PATHS-1:0][1:0] eff_src;
    logic [PATHS-1:0] sleeping;
    logic [PATHS-1:0] sel_tick;
    logic [31:0] status_word;
    logic wr_fire;
    logic [2:0] wr_idx;
    logic [2:0] rd_idx;

    localparam int CODE_LSB_FIRST [4] = '{`CMX_POST_A_LSB, `CMX_POST_B_LSB,
        `CMX_CODE_C1_LSB, `CMX_CODE_D1_LSB};
    localparam int CODE_LSB_SECOND [4] = '{`CMX_POST_A_LSB, `CMX_POST_B_LSB,
        `CMX_CODE_C2_LSB, `CMX_CODE_D2_LSB};
    localparam int SRC_LSB_FIRST [4] = '{`CMX_SRC_A_LSB, `CMX_SRC_B_LSB,
        `CMX_SRC_C1_LSB, `CMX_SRC_D1_LSB};
    localparam int SRC_LSB_SECOND [4] = '{`CMX_SRC_A_LSB, `CMX_SRC_B_LSB,
        `CMX_SRC_C2_LSB, `CMX_SRC_D2_LSB};

    assign image_flat = state.image;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic logic [2:0] cmx_reg_index(input logic [7:0] addr);
        logic [2:0] idx;
        idx = 3'h7;
        case (addr)
            `CMX_IMG0_OFS: idx = 3'h0;
            `CMX_IMG1_OFS: idx = 3'h1;
            `CMX_IMG2_OFS: idx = 3'h2;
            `CMX_IMG3_OFS: idx = 3'h3;
            `CMX_STATUS_OFS: idx = 3'h4;
            default: idx = 3'h7;
        endcase
        return idx;
    endfunction : cmx_reg_index

    // ----------------------------------------
    // output paths
    // ----------------------------------------
    generate
        for (genvar i = 0; i < PATHS; i++)
        begin : g_path
            // select pin read every cycle, no reload step
            assign eff_code[i] = cd_config_select ?
                image_flat[CODE_LSB_SECOND[i] +: 4] : image_flat[CODE_LSB_FIRST[i] +: 4];
            assign eff_src[i] = cd_config_select ?
                image_flat[SRC_LSB_SECOND[i] +: 2] : image_flat[SRC_LSB_FIRST[i] +: 2];
            assign sleeping[i] = image_flat[`CMX_SLEEP_A_BIT + i] & power_down_pin
                & run_mode;
            // source switch is immediate and may cut a period short
            assign sel_tick[i] = src_tick[eff_src[i]];

            cmx_post_divider #(
                .CNT_W(CNT_W)
            ) u_div (
                .aclk(aclk),
                .aresetn(aresetn),
                .src_tick(sel_tick[i]),
                .divide_code(eff_code[i]),
                .sleep(sleeping[i]),
                .div_tick(out_tick[i]),
                .div_clk(out_clk[i])
            );
        end
    endgenerate

    // ----------------------------------------
    // status word
    // ----------------------------------------
    always_comb
    begin
        status_word = 32'h0;
        status_word[`CMX_STAT_CODE_LSB +: 16] = eff_code;
        status_word[`CMX_STAT_SRC_LSB +: 8] = eff_src;
        status_word[`CMX_STAT_SLEEP_LSB +: 4] = sleeping;
        status_word[`CMX_STAT_SELECT_BIT] = cd_config_select;
    end

    // ----------------------------------------
    // register bus and tuning
    // ----------------------------------------
    assign wr_fire = state.aw_got & state.w_got & ~state.bvalid;
    assign wr_idx = cmx_reg_index(state.aw_addr);
    assign rd_idx = cmx_reg_index(axi_req.araddr);

    always_comb
    begin
        next_state = state;

        // write address and data, either order
        if (axi_req.awvalid && state.aw_rdy)
        begin
            next_state.aw_addr = axi_req.awaddr;
            next_state.aw_got = 1'b1;
            next_state.aw_rdy = 1'b0;
        end
        if (axi_req.wvalid && state.w_rdy)
        begin
            next_state.wdata = axi_req.wdata;
            next_state.wstrb = axi_req.wstrb;
            next_state.w_got = 1'b1;
            next_state.w_rdy = 1'b0;
        end

        // write commit
        if (wr_fire)
        begin
            next_state.aw_got = 1'b0;
            next_state.w_got = 1'b0;
            next_state.bvalid = 1'b1;
            if (wr_idx < 3'h4)
            begin
                for (int b = 0; b < 4; b++)
                begin
                    if (state.wstrb[b])
                        next_state.image[wr_idx[1:0]][b*8 +: 8] = state.wdata[b*8 +: 8];
                end
                next_state.bresp = `CMX_RESP_OKAY;
            end
            else
            begin
                next_state.bresp = `CMX_RESP_SLVERR;
            end
        end
        if (state.bvalid && axi_req.bready)
        begin
            next_state.bvalid = 1'b0;
            next_state.aw_rdy = 1'b1;
            next_state.w_rdy = 1'b1;
        end

        // read
        if (axi_req.arvalid && state.ar_rdy)
        begin
            next_state.ar_rdy = 1'b0;
            next_state.rvalid = 1'b1;
            next_state.rresp = `CMX_RESP_OKAY;
            case (rd_idx)
                3'h0, 3'h1, 3'h2, 3'h3: next_state.rdata = state.image[rd_idx[1:0]];
                3'h4: next_state.rdata = status_word;
                default:
                begin
                    next_state.rdata = 32'h0;
                    next_state.rresp = `CMX_RESP_SLVERR;
                end
            endcase
        end
        if (state.rvalid && axi_req.rready)
        begin
            next_state.rvalid = 1'b0;
            next_state.ar_rdy = 1'b1;
        end

        // pll tuning levels; analog loop slews on change
        next_state.tune[0].filter_long = image_flat[`CMX_FILTER_A_BIT];
        next_state.tune[0].pump_high = image_flat[`CMX_PUMP_A_BIT];
        next_state.tune[1].filter_long = image_flat[`CMX_FILTER_B_BIT];
        next_state.tune[1].pump_high = image_flat[`CMX_PUMP_B_BIT];
        next_state.tune[2].filter_long = cd_config_select ?
            image_flat[`CMX_FILTER_C2_BIT] : image_flat[`CMX_FILTER_C1_BIT];
        next_state.tune[2].pump_high = cd_config_select ?
            image_flat[`CMX_PUMP_C2_BIT] : image_flat[`CMX_PUMP_C1_BIT];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= '0;
            state.image <= `CMX_IMAGE_RESET;
            state.aw_rdy <= 1'b1;
            state.w_rdy <= 1'b1;
            state.ar_rdy <= 1'b1;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign axi_rsp.awready = state.aw_rdy;
    assign axi_rsp.wready = state.w_rdy;
    assign axi_rsp.bvalid = state.bvalid;
    assign axi_rsp.bresp = state.bresp;
    assign axi_rsp.arready = state.ar_rdy;
    assign axi_rsp.rvalid = state.rvalid;
    assign axi_rsp.rdata = state.rdata;
    assign axi_rsp.rresp = state.rresp;
    assign pll_tune = state.tune;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence img3_full_write;
        wr_fire && wr_idx == 3'h3 && state.wstrb == 4'hf;
    endsequence

    sequence path_pass_tick(int p);
        sel_tick[p] && eff_code[p] == 4'h0 && !sleeping[p];
    endsequence

    post_a_field_a: assert property (img3_full_write |=>
        eff_code[0] == $past(state.wdata[3:0]))
        else $error("path a code not taken from image");
    post_b_field_a: assert property (img3_full_write |=>
        eff_code[1] == $past(state.wdata[7:4]))
        else $error("path b code not taken from image");
    post_c_pick_a: assert property (img3_full_write |=> eff_code[2] ==
        (cd_config_select ? $past(state.wdata[19:16]) : $past(state.wdata[11:8])))
        else $error("path c code does not follow select pin");
    post_d_pick_a: assert property (img3_full_write |=> eff_code[3] ==
        (cd_config_select ? $past(state.wdata[23:20]) : $past(state.wdata[15:12])))
        else $error("path d code does not follow select pin");
    src_a_route_a: assert property (path_pass_tick(0) |=> out_tick[0])
        else $error("path a missed its selected source tick");
    src_d_route_a: assert property (src_tick[image_flat[`CMX_SRC_D2_LSB +: 2]]
        && cd_config_select && eff_code[3] == 4'h0 && !sleeping[3] |=> out_tick[3])
        else $error("path d second source not routed");
    pll_c_tune_a: assert property ($stable(image_flat) ##1 $stable(image_flat) |->
        pll_tune[2].filter_long == $past(cd_config_select ? image_flat[`CMX_FILTER_C2_BIT]
        : image_flat[`CMX_FILTER_C1_BIT]))
        else $error("pll c filter not from selected bit");
    pump_a_tune_a: assert property (1'b1 |=> pll_tune[0].pump_high ==
        $past(image_flat[`CMX_PUMP_A_BIT]) && pll_tune[1].filter_long ==
        $past(image_flat[`CMX_FILTER_B_BIT]))
        else $error("pll a or b tuning not from image");
    sleep_stop_a: assert property (sleeping[0] [*2] |-> !out_tick[0] && !out_clk[0])
        else $error("path a ran while asleep");
    reset_image_a: assert property ($past(!aresetn) |-> image_flat == 128'h0
        && !axi_rsp.bvalid && !axi_rsp.rvalid)
        else $error("image not cleared by reset");
    wr_answer_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
        && axi_rsp.wready |=> ##1 axi_rsp.bvalid)
        else $error("write response late");

endmodule : cmx_clock_router

/* File: hdl/cmx_params.svh */
`ifndef CMX_PARAMS_SVH
`define CMX_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CMX_IMG0_OFS 8'h00
`define CMX_IMG1_OFS 8'h04
`define CMX_IMG2_OFS 8'h08
`define CMX_IMG3_OFS 8'h0c
`define CMX_STATUS_OFS 8'h10

// ----------------------------------------
// configuration image field positions
// ----------------------------------------
`define CMX_POST_A_LSB 96
`define CMX_POST_B_LSB 100
`define CMX_CODE_C1_LSB 104
`define CMX_CODE_D1_LSB 108
`define CMX_CODE_C2_LSB 112
`define CMX_CODE_D2_LSB 116
`define CMX_SLEEP_A_BIT 120
`define CMX_SRC_A_LSB 22
`define CMX_SRC_B_LSB 46
`define CMX_SRC_C1_LSB 70
`define CMX_SRC_D1_LSB 94
`define CMX_SRC_C2_LSB 124
`define CMX_SRC_D2_LSB 126
`define CMX_FILTER_A_BIT 20
`define CMX_FILTER_B_BIT 44
`define CMX_FILTER_C1_BIT 68
`define CMX_FILTER_C2_BIT 92
`define CMX_PUMP_A_BIT 19
`define CMX_PUMP_B_BIT 43
`define CMX_PUMP_C1_BIT 67
`define CMX_PUMP_C2_BIT 91

// ----------------------------------------
// status word layout
// ----------------------------------------
`define CMX_STAT_CODE_LSB 0
`define CMX_STAT_SRC_LSB 16
`define CMX_STAT_SLEEP_LSB 24
`define CMX_STAT_SELECT_BIT 28

// ----------------------------------------
// reset values and responses
// ----------------------------------------
`define CMX_IMAGE_RESET 128'h0
`define CMX_RESP_OKAY 2'b00
`define CMX_RESP_SLVERR 2'b10

`endif

/* File: hdl/cmx_pkg.sv */
package cmx_pkg;

    // ----------------------------------------
    // axi4-lite carriers
    // ----------------------------------------
    typedef struct packed
    {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } cmx_axi_req_t;

    typedef struct packed
    {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cmx_axi_rsp_t;

    // ----------------------------------------
    // clock sources and pll tuning
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        CMX_SRC_REF,
        CMX_SRC_PLL_A,
        CMX_SRC_PLL_B,
        CMX_SRC_PLL_C
    } cmx_src_t;

    typedef struct packed
    {
        logic filter_long;
        logic pump_high;
    } cmx_pll_tune_t;

endpackage : cmx_pkg

/* File: hdl/cmx_post_divider.sv */
module cmx_post_divider #(
    parameter int CNT_W = 6
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic src_tick,
    input wire logic [3:0] divide_code,
    input wire logic sleep,
    output logic div_tick,
    output logic div_clk
);
    import cmx_pkg::*;

    typedef struct packed
    {
        logic [CNT_W-1:0] count;
        logic tick;
        logic clk;
    } cmx_div_state_t;

    cmx_div_state_t state;
    cmx_div_state_t next_state;

    // ----------------------------------------
    // code to ratio
    // ----------------------------------------
    function automatic logic [CNT_W-1:0] cmx_ratio(input logic [3:0] code);
        logic [CNT_W-1:0] r;
        r = CNT_W'(1);
        case (code)
            4'h0: r = CNT_W'(1);
            4'h1: r = CNT_W'(2);
            4'h2: r = CNT_W'(3);
            4'h3: r = CNT_W'(4);
            4'h4: r = CNT_W'(5);
            4'h5: r = CNT_W'(6);
            4'h6: r = CNT_W'(8);
            4'h7: r = CNT_W'(9);
            4'h8: r = CNT_W'(10);
            4'h9: r = CNT_W'(12);
            4'ha: r = CNT_W'(15);
            4'hb: r = CNT_W'(16);
            4'hc: r = CNT_W'(18);
            4'hd: r = CNT_W'(20);
            4'he: r = CNT_W'(25);
            default: r = CNT_W'(50);
        endcase
        return r;
    endfunction : cmx_ratio

    // ----------------------------------------
    // counter
    // ----------------------------------------
    always_comb
    begin
        next_state = state;
        next_state.tick = 1'b0;
        if (sleep)
        begin
            next_state.count = '0;
            next_state.clk = 1'b0;
        end
        else if (src_tick)
        begin
            // no restart on a code change: a short period may appear
            if (state.count >= cmx_ratio(divide_code) - CNT_W'(1))
            begin
                next_state.count = '0;
                next_state.tick = 1'b1;
                next_state.clk = ~state.clk;
            end
            else
            begin
                next_state.count = state.count + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state <= '0;
        else
            state <= next_state;
    end

    assign div_tick = state.tick;
    assign div_clk = state.clk;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sleep_quiet_a: assert property (sleep |=> !div_tick && !div_clk && state.count == '0)
        else $error("divider active while asleep");
    div_by_two_a: assert property (src_tick && !sleep && divide_code == 4'h1 && state.count == '0
        |=> !div_tick && state.count == CNT_W'(1))
        else $error("divide by two produced early tick");
    tick_restarts_a: assert property (div_tick |-> state.count == '0 && $changed(div_clk))
        else $error("tick without counter restart");

endmodule : cmx_post_divider

/* File: sim/cmx_load_model.sv */
module cmx_load_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] out_tick,
    input wire logic [3:0] out_clk,
    output logic [3:0][15:0] tick_count,
    output logic [3:0][7:0] last_gap,
    output logic [3:0] clk_bad
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0][7:0] since;
    logic [3:0] clk_seen;

    // ----------------------------------------
    // tick counting, period capture, clock toggle watch
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        clk_seen <= out_clk;
        if (!aresetn)
        begin
            tick_count <= '0;
            last_gap <= '0;
            since <= '0;
            clk_bad <= '0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (out_tick[i])
                begin
                    tick_count[i] <= tick_count[i] + 16'h1;
                    last_gap[i] <= since[i];
                    since[i] <= 8'h1;
                    if (out_clk[i] === clk_seen[i])
                        clk_bad[i] <= 1'h1;
                end
                else if (since[i] != 8'hff)
                    since[i] <= since[i] + 8'h1;
            end
        end
    end
endmodule : cmx_load_model

/* File: sim/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cmx_pkg::*;

    logic aclk;
    logic aresetn;
    cmx_axi_req_t req;
    cmx_axi_rsp_t rsp;
    logic sel_pin;
    logic pwr_dn_pin;
    logic run_pin;
    logic [3:0] src;
    logic [3:0] tick;
    logic [3:0] oclk;
    cmx_pll_tune_t [2:0] tune;
    logic [3:0][15:0] tcnt;
    logic [3:0][7:0] lgap;
    logic [3:0] clk_bad;
    int miscompares;
    int n_checks;
    localparam int RATIO [16] = '{1, 2, 3, 4, 5, 6, 8, 9, 10, 12, 15, 16, 18, 20, 25, 50};
    localparam logic [31:0] TUNE [4] = '{32'h26, 32'h16, 32'h19, 32'h29};

    cmx_clock_router i_cmx_clock_router (
        .aclk(aclk),
        .aresetn(aresetn),
        .axi_req(req),
        .axi_rsp(rsp),
        .cd_config_select(sel_pin),
        .power_down_pin(pwr_dn_pin),
        .run_mode(run_pin),
        .src_tick(src),
        .out_tick(tick),
        .out_clk(oclk),
        .pll_tune(tune)
    );

    cmx_load_model i_cmx_load_model (
        .aclk(aclk),
        .aresetn(aresetn),
        .out_tick(tick),
        .out_clk(oclk),
        .tick_count(tcnt),
        .last_gap(lgap),
        .clk_bad(clk_bad)
    );

    // ----------------------------------------
    // reporting
    // ----------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            miscompares++;
        end
    endtask : chk

    task automatic hang(input int n);
        if (n > 400)
        begin
            $display("[ERR] %0t wait ran out got %h exp %h", $time, n, 400);
            miscompares++;
            wrap_up();
        end
    endtask : hang

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    // ----------------------------------------
    // axi4-lite master
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        req.awvalid <= 1'h1;
        req.awaddr <= a;
        req.wvalid <= 1'h1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'h1;
        forever
        begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready)
                req.awvalid <= 1'h0;
            if (req.wvalid && rsp.wready)
                req.wvalid <= 1'h0;
            if (rsp.bvalid)
                break;
            n++;
            hang(n);
        end
        req.bready <= 1'h0;
        chk(32'(rsp.bresp), 32'(er));
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        req.arvalid <= 1'h1;
        req.araddr <= a;
        req.rready <= 1'h1;
        forever
        begin
            @(posedge aclk);
            if (req.arvalid && rsp.arready)
                req.arvalid <= 1'h0;
            if (rsp.rvalid)
                break;
            n++;
            hang(n);
        end
        req.rready <= 1'h0;
        chk(rsp.rdata, ed);
        chk(32'(rsp.rresp), 32'(er));
    endtask : rd

    // ----------------------------------------
    // output observation
    // ----------------------------------------
    task automatic gap(input int p, input int exp);
        logic [15:0] c0;
        int n;
        c0 = tcnt[p];
        n = 0;
        while (16'(tcnt[p] - c0) < 16'h3)
        begin
            @(posedge aclk);
            n++;
            hang(n);
        end
        chk(32'(lgap[p]), exp);
    endtask : gap

    task automatic burst(input logic [3:0] on);
        logic [3:0][15:0] c0;
        repeat (3) @(posedge aclk);
        c0 = tcnt;
        repeat (8) @(posedge aclk);
        for (int i = 0; i < 4; i++)
            chk(32'(16'(tcnt[i] - c0[i])), on[i] ? 32'h8 : 32'h0);
    endtask : burst

    initial
    begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        aresetn = 1'h0;
        req = '0;
        sel_pin = 1'h0;
        pwr_dn_pin = 1'h0;
        run_pin = 1'h0;
        src = 4'h0;
        miscompares = 0;
        n_checks = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < 5; i++)
            rd(8'(4 * i), 32'h0, 2'h0);
        rd(8'h20, 32'h0, 2'h2);
        wr(8'h10, 32'hffff_ffff, 2'h2);
        rd(8'h10, 32'h0, 2'h0);
        chk(32'(tune), 32'h0);
        src <= 4'h1;
        burst(4'hf);
        done("reset");

        for (int c = 0; c < 16; c++)
        begin
            wr(8'h0c, 32'(((15 - c) << 4) | c), 2'h0);
            gap(0, RATIO[c]);
            gap(1, RATIO[15 - c]);
        end
        done("divide");

        for (int s = 0; s < 4; s++)
        begin
            wr(8'h00, 32'(s << 22), 2'h0);
            wr(8'h04, 32'(s << 14), 2'h0);
            wr(8'h08, 32'((s << 6) | (s << 30)), 2'h0);
            wr(8'h0c, 32'(((3 - s) << 28) | ((3 - s) << 30)), 2'h0);
            for (int k = 0; k < 8; k++)
            begin
                sel_pin <= k[2];
                src <= 4'(1 << k[1:0]);
                burst({{2{(k[2] ? 3 - s : s) == k[1:0]}}, {2{s == k[1:0]}}});
            end
        end
        done("source");

        wr(8'h08, 32'h0, 2'h0);
        src <= 4'h1;
        wr(8'h0c, 32'h00e9_3100, 2'h0);
        for (int p = 0; p < 2; p++)
        begin
            sel_pin <= p[0];
            gap(2, p ? 12 : 2);
            gap(3, p ? 25 : 4);
        end
        done("select");

        for (int f = 0; f < 2; f++)
        begin
            wr(8'h00, f ? 32'h0008_0000 : 32'h0010_0000, 2'h0);
            wr(8'h04, f ? 32'h0000_1000 : 32'h0000_0800, 2'h0);
            wr(8'h08, f ? 32'h1000_0008 : 32'h0800_0010, 2'h0);
            for (int p = 0; p < 2; p++)
            begin
                sel_pin <= p[0];
                repeat (3) @(posedge aclk);
                chk(32'(tune), TUNE[f * 2 + p]);
            end
        end
        done("tuning");

        for (int m = 0; m < 4; m++)
        begin
            wr(8'h0c, m == 3 ? 32'h0 : 32'h0100_0000, 2'h0);
            pwr_dn_pin <= (m != 1);
            run_pin <= (m != 2);
            burst(m == 0 ? 4'he : 4'hf);
        end
        chk(32'(clk_bad), 32'h0);
        done("sleep");
        wrap_up();
    end
endmodule : tb
